// *** verilog/sqcr_pkg.sv ***
// Constants shared by the queue-control register bank and its scheduler
package sqcr_pkg;

   // ---------------------------------------------------------------
   // Widths and counts
   // ---------------------------------------------------------------
   localparam int unsigned ADDR_W      = 12;
   localparam int unsigned DATA_W      = 32;
   localparam int unsigned NUM_QUEUES  = 16;
   localparam int unsigned FILTER_W    = 16;
   localparam int unsigned NUM_FLOW_RG = 8;
   localparam int unsigned NUM_MAP_RG  = 4;
   localparam int unsigned NUM_SLOTS   = 16;
   localparam int unsigned SLOT_W      = 8;

   // ---------------------------------------------------------------
   // Register offsets (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [11:0] FLOW_BASE_ADDR   = 12'h704;
   localparam logic [11:0] RX_TEARDOWN_ADDR = 12'h740;
   localparam logic [11:0] RX_ORDER_ADDR    = 12'h744;
   localparam logic [11:0] WRR_BASE_ADDR    = 12'h7e0;
   localparam logic [11:0] WRR_STATUS_ADDR  = 12'h7f0;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int unsigned FLOW_ODD_LSB = 16;
   localparam int unsigned MAP_QSEL_LSB = 0;
   localparam int unsigned MAP_CNT_LSB  = 4;
   localparam int unsigned MAP_FIELD_W  = 4;

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [31:0] FLOW_RESET  = 32'hffffffff;
   localparam logic [15:0] ORDER_RESET = 16'h0000;
   localparam logic [31:0] WRR_RESET [NUM_MAP_RG] = '{
      32'h03020100, 32'h07060504, 32'h0b0a0908, 32'h0f0e0d0c};

endpackage : sqcr_pkg

// *** verilog/sqcr_wrr_sched.sv ***
// Weighted round-robin walker over the sixteen transmit mapper slots
`timescale 1ns/100ps
`default_nettype none
module sqcr_wrr_sched
   import sqcr_pkg::*;
#(
   parameter int unsigned SLOTS = NUM_SLOTS
) (
   // Clock and reset
   input  wire logic         sys_clk,
   input  wire logic         sys_rst,
   // Mapper slots, slot s in bits [8s+7:8s]
   input  wire logic [127:0] map_slots,
   // Transmit engine
   input  wire logic [15:0]  tx_queue_pending,
   input  wire logic         tx_msg_done,
   output logic              tx_serve_valid,
   output logic [3:0]        tx_serve_queue,
   // Status
   output logic [3:0]        slot_idx,
   output logic [3:0]        slot_taken
);

   if (SLOTS != NUM_SLOTS) begin : g_slot_chk
      $error("sqcr_wrr_sched: slot count fixed");
   end

   logic [3:0] slot_q, slot_d;
   logic [3:0] taken_q, taken_d;
   logic [3:0] cur_cnt;

   // ---------------------------------------------------------------
   // Slot walk
   // ---------------------------------------------------------------
   always_comb begin
      tx_serve_queue = map_slots[int'(slot_q)*SLOT_W + MAP_QSEL_LSB +:
                                 MAP_FIELD_W];
      cur_cnt        = map_slots[int'(slot_q)*SLOT_W + MAP_CNT_LSB +:
                                 MAP_FIELD_W];
      // Empty or idle slots are skipped so one idle queue cannot stall
      tx_serve_valid = (cur_cnt != 4'h0) && tx_queue_pending[tx_serve_queue];
      slot_d  = slot_q;
      taken_d = taken_q;
      if (!tx_serve_valid) begin
         slot_d  = 4'(slot_q + 4'h1);
         taken_d = 4'h0;
      end else if (tx_msg_done) begin
         if (4'(taken_q + 4'h1) == cur_cnt) begin
            slot_d  = 4'(slot_q + 4'h1);
            taken_d = 4'h0;
         end else begin
            taken_d = 4'(taken_q + 4'h1);
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         slot_q  <= 4'h0;
         taken_q <= 4'h0;
      end else begin
         slot_q  <= slot_d;
         taken_q <= taken_d;
      end
   end

   assign slot_idx   = slot_q;
   assign slot_taken = taken_q;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   serve_pending_a: assert property (tx_serve_valid |->
      tx_queue_pending[tx_serve_queue] && cur_cnt != 4'h0)
      else $error("served queue not pending or slot empty");
   // Reset is sampled here so the edge that releases it starts no attempt
   slot_skip_a: assert property (!sys_rst && !tx_serve_valid |=>
      slot_q == 4'($past(slot_q) + 4'h1) && taken_q == 4'h0)
      else $error("idle slot was not skipped");
   slot_advance_a: assert property (tx_serve_valid && tx_msg_done &&
      4'(taken_q + 4'h1) == cur_cnt |=> slot_q == 4'($past(slot_q) + 4'h1)
      && taken_q == 4'h0)
      else $error("slot did not advance after its count");
   slot_hold_a: assert property (tx_serve_valid && tx_msg_done &&
      4'(taken_q + 4'h1) != cur_cnt |=> $stable(slot_q)
      && taken_q == 4'($past(taken_q) + 4'h1))
      else $error("slot left before its count");

   wrap_c: cover property (slot_q == 4'hf ##1 slot_q == 4'h0);
   burst_c: cover property (tx_serve_valid && tx_msg_done ##1
                            tx_serve_valid && tx_msg_done && taken_q != 4'h0);

endmodule // sqcr_wrr_sched
`default_nettype wire

// *** verilog/sqcr_regs.sv ***
// Queue-control register bank of the message engine
//
// Notes on behaviour
// - Filter bit set lets queue carry flow
// - Writing one pulses that receive queue teardown
// - Teardown upper half reads zero, ignores writes
// - Order bit one forces in-order delivery
// - Transmit queues served by sixteen-slot round robin
// - Two filters per register, even queue low
// - Slot serves count messages, then next slot
//
// Design decision made here: strobed register access.
`timescale 1ns/100ps
`default_nettype none
module sqcr_regs
   import sqcr_pkg::*;
#(
   parameter int unsigned QUEUES = NUM_QUEUES
) (
   // Clock and reset
   input  wire logic         sys_clk,
   input  wire logic         sys_rst,
   // Register port
   input  wire logic [11:0]  reg_addr,
   input  wire logic [31:0]  reg_wdata,
   input  wire logic         reg_wr,
   input  wire logic         reg_rd,
   output logic      [31:0]  reg_rdata,
   // Receive queue control
   output logic      [15:0]  rx_queue_kill_bit,
   output logic      [15:0]  rx_in_order,
   // Transmit flow filters, queue q in bits [16q+15:16q]
   output logic      [255:0] tx_flow_filter,
   // Transmit scheduling
   input  wire logic [15:0]  tx_queue_pending,
   input  wire logic         tx_msg_done,
   output logic              tx_serve_valid,
   output logic      [3:0]   tx_serve_queue
);

   // The queue count is tied to the register map, other values refused
   if (QUEUES != NUM_QUEUES) begin : g_queue_chk
      $error("sqcr_regs: queue count fixed");
   end

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   logic [31:0]  flow_q [NUM_FLOW_RG];
   logic [31:0]  flow_d [NUM_FLOW_RG];
   logic [31:0]  map_q  [NUM_MAP_RG];
   logic [31:0]  map_d  [NUM_MAP_RG];
   logic [15:0]  order_q, order_d;
   logic [15:0]  kill_q, kill_d;
   logic [31:0]  rdata_q, rdata_d;

   logic [11:0]  flow_off;
   logic [11:0]  map_off;
   logic         flow_hit;
   logic         map_hit;
   logic [2:0]   flow_idx;
   logic [1:0]   map_idx;
   logic [127:0] map_flat;
   logic [3:0]   slot_idx;
   logic [3:0]   slot_taken;
   logic         kill_hit;
   logic         order_hit;
   logic         status_hit;

   // ---------------------------------------------------------------
   // Address decode
   // ---------------------------------------------------------------
   always_comb begin
      flow_off = 12'(reg_addr - FLOW_BASE_ADDR);
      map_off  = 12'(reg_addr - WRR_BASE_ADDR);
      // Underflow wraps high, so one range test covers both ends
      flow_hit = (flow_off[11:5] == 7'h00) && (flow_off[1:0] == 2'h0);
      map_hit  = (map_off[11:4] == 8'h00) && (map_off[1:0] == 2'h0);
      flow_idx = flow_off[4:2];
      map_idx  = map_off[3:2];
      kill_hit   = (reg_addr == RX_TEARDOWN_ADDR);
      order_hit  = (reg_addr == RX_ORDER_ADDR);
      status_hit = (reg_addr == WRR_STATUS_ADDR);
   end

   // ---------------------------------------------------------------
   // Register writes
   // ---------------------------------------------------------------
   always_comb begin
      for (int i = 0; i < NUM_FLOW_RG; i++) begin
         flow_d[i] = flow_q[i];
      end
      for (int i = 0; i < NUM_MAP_RG; i++) begin
         map_d[i] = map_q[i];
      end
      order_d = order_q;
      // Teardown bits are strobes: they live one cycle, never stored
      kill_d  = 16'h0000;
      if (reg_wr) begin
         if (flow_hit) begin
            flow_d[flow_idx] = reg_wdata;
         end
         if (map_hit) begin
            map_d[map_idx] = reg_wdata;
         end
         if (kill_hit) begin
            kill_d = reg_wdata[15:0];
         end
         if (order_hit) begin
            order_d = reg_wdata[15:0];
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         for (int i = 0; i < NUM_FLOW_RG; i++) begin
            flow_q[i] <= FLOW_RESET;
         end
         for (int i = 0; i < NUM_MAP_RG; i++) begin
            map_q[i] <= WRR_RESET[i];
         end
         order_q <= ORDER_RESET;
         kill_q  <= 16'h0000;
      end else begin
         for (int i = 0; i < NUM_FLOW_RG; i++) begin
            flow_q[i] <= flow_d[i];
         end
         for (int i = 0; i < NUM_MAP_RG; i++) begin
            map_q[i] <= map_d[i];
         end
         order_q <= order_d;
         kill_q  <= kill_d;
      end
   end

   // ---------------------------------------------------------------
   // Register reads
   // ---------------------------------------------------------------
   always_comb begin
      rdata_d = 32'h00000000;
      if (reg_rd) begin
         if (flow_hit) begin
            rdata_d = flow_q[flow_idx];
         end else if (map_hit) begin
            rdata_d = map_q[map_idx];
         end else if (order_hit) begin
            rdata_d = {16'h0000, order_q};
         end else if (status_hit) begin
            rdata_d = {19'h00000, tx_serve_valid, slot_taken, slot_idx,
                       tx_serve_queue};
         end else begin
            // Teardown and unmapped words read as zero
            rdata_d = 32'h00000000;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         rdata_q <= 32'h00000000;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   always_comb begin
      for (int i = 0; i < NUM_FLOW_RG; i++) begin
         tx_flow_filter[i*32 +: 16] = flow_q[i][15:0];
         tx_flow_filter[i*32 + FLOW_ODD_LSB +: 16] =
            flow_q[i][FLOW_ODD_LSB +: 16];
      end
      for (int i = 0; i < NUM_MAP_RG; i++) begin
         map_flat[i*32 +: 32] = map_q[i];
      end
   end

   // Read data, teardown strobes and order bits come straight from their registers
   assign reg_rdata         = rdata_q;
   assign rx_queue_kill_bit = kill_q;
   assign rx_in_order       = order_q;

   // ---------------------------------------------------------------
   // Round-robin scheduler
   // ---------------------------------------------------------------
   sqcr_wrr_sched #(
      .SLOTS            (NUM_SLOTS)
   ) u_sched (
      .sys_clk          (sys_clk),
      .sys_rst          (sys_rst),
      .map_slots        (map_flat),
      .tx_queue_pending (tx_queue_pending),
      .tx_msg_done      (tx_msg_done),
      .tx_serve_valid   (tx_serve_valid),
      .tx_serve_queue   (tx_serve_queue),
      .slot_idx         (slot_idx),
      .slot_taken       (slot_taken)
   );

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   kill_pulse_a: assert property (reg_wr && reg_addr == RX_TEARDOWN_ADDR
      |=> rx_queue_kill_bit == 16'($past(reg_wdata))
      ##1 rx_queue_kill_bit == 16'h0000 || $past(reg_wr))
      else $error("teardown strobe does not follow the write");

   kill_quiet_a: assert property (
      !(reg_wr && reg_addr == RX_TEARDOWN_ADDR)
      |=> rx_queue_kill_bit == 16'h0000)
      else $error("teardown strobe without a write");

   kill_read_a: assert property (reg_rd && reg_addr == RX_TEARDOWN_ADDR
      |=> reg_rdata == 32'h00000000)
      else $error("teardown word did not read zero");

   order_write_a: assert property (reg_wr && reg_addr == RX_ORDER_ADDR
      |=> rx_in_order == 16'($past(reg_wdata)))
      else $error("order control not taken");

   order_read_a: assert property (reg_rd && reg_addr == RX_ORDER_ADDR
      |=> reg_rdata == {16'h0000, rx_in_order})
      else $error("order control read mismatch");

   flow_pair_a: assert property (reg_wr &&
      reg_addr == 12'(FLOW_BASE_ADDR + 12'h010) |=>
      tx_flow_filter[128 +: 16] == 16'($past(reg_wdata)) &&
      tx_flow_filter[144 +: 16] == 16'($past(reg_wdata) >> 16))
      else $error("queue eight and nine filters misplaced");

   flow_read_a: assert property (reg_rd && flow_hit |=>
      reg_rdata == {tx_flow_filter[$past(flow_idx)*32 + 16 +: 16],
                    tx_flow_filter[$past(flow_idx)*32 +: 16]})
      else $error("flow filter read mismatch");

   map_read_a: assert property (reg_rd && reg_addr == WRR_BASE_ADDR |=>
      reg_rdata == map_flat[31:0])
      else $error("mapper word read mismatch");

   rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h00000000)
      else $error("read data stand without a read");

   flow_write_a: assert property (reg_wr && flow_hit |=>
      tx_flow_filter[$past(flow_idx)*32 +: 32] == $past(reg_wdata))
      else $error("flow filter word not taken");

   flow_hold_a: assert property (!(reg_wr && flow_hit) |=>
      $stable(tx_flow_filter))
      else $error("flow filter changed without a write");

   order_hold_a: assert property (!(reg_wr && order_hit) |=>
      $stable(rx_in_order))
      else $error("order control changed without a write");

   order_upper_a: assert property (reg_rd && order_hit |=>
      reg_rdata[31:16] == 16'h0000)
      else $error("order control upper half not zero");

   map_write_a: assert property (reg_wr && map_hit |=>
      map_flat[$past(map_idx)*32 +: 32] == $past(reg_wdata))
      else $error("mapper word not taken");

   map_hold_a: assert property (!(reg_wr && map_hit) |=>
      $stable(map_flat))
      else $error("mapper slots changed without a write");

   // Status is live scheduler state, so it is held against the read cycle
   status_read_a: assert property (reg_rd && status_hit |=>
      reg_rdata[31:13] == 19'h0 &&
      reg_rdata[12] == $past(tx_serve_valid) &&
      reg_rdata[3:0] == $past(tx_serve_queue))
      else $error("scheduler status read mismatch");

   unmapped_read_a: assert property (reg_rd && !flow_hit && !map_hit &&
      !order_hit && !status_hit |=> reg_rdata == 32'h00000000)
      else $error("unmapped word did not read zero");

   kill_upper_a: assert property (reg_wr && kill_hit &&
      reg_wdata[15:0] == 16'h0000 |=> rx_queue_kill_bit == 16'h0000)
      else $error("teardown upper half reached the strobes");

   misalign_wr_a: assert property (reg_wr && reg_addr[1:0] != 2'h0 |=>
      $stable(tx_flow_filter) && $stable(rx_in_order))
      else $error("misaligned write changed a register");

   kill_c: cover property (reg_wr && reg_addr == RX_TEARDOWN_ADDR
                           && reg_wdata[15:0] != 16'h0000);
   flow_c: cover property (reg_wr && flow_hit ##1 reg_rd && flow_hit);
   serve_c: cover property (tx_serve_valid && tx_msg_done);

endmodule // sqcr_regs
`default_nettype wire

// *** tb/sqcr_tx_engine_model.sv ***
// Transmit engine model that ends messages on whichever queue is being served
`timescale 1ns/100ps
`default_nettype none
module sqcr_tx_engine_model (
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        sys_rst,
   // Bench control
   input  wire logic [15:0] pend_mask,
   input  wire logic        stall_en,
   // Scheduler side
   input  wire logic        tx_serve_valid,
   output logic      [15:0] tx_queue_pending,
   output logic             tx_msg_done
);
   logic [1:0] pace_q;
   // Queues stay full unless the bench empties them
   assign tx_queue_pending = pend_mask;
   // Slow mode ends one message every fourth cycle, never while idle
   assign tx_msg_done = tx_serve_valid & (~stall_en | (pace_q == 2'h0));
   always_ff @(posedge sys_clk) begin
      if (sys_rst) pace_q <= 2'h0;
      else pace_q <= pace_q + 2'h1;
   end
endmodule // sqcr_tx_engine_model
`default_nettype wire

// *** tb/srio_queue_control_regs_tb.sv ***
// Self-checking bench for the queue-control register bank
`timescale 1ns/100ps
`default_nettype none
module srio_queue_control_regs_tb;
   import sqcr_pkg::*;
   logic         sys_clk, sys_rst, reg_wr, reg_rd, stall_en;
   logic         tx_serve_valid, tx_msg_done, mon_on, first, part;
   logic [11:0]  reg_addr;
   logic [31:0]  reg_wdata, reg_rdata, rd_v, lfsr, d;
   logic [15:0]  rx_queue_kill_bit, rx_in_order, tx_queue_pending, pend_mask;
   logic [255:0] tx_flow_filter;
   logic [3:0]   tx_serve_queue, prev_q;
   logic [3:0]   cnt_tab [16];
   int           num_errors, checks, run_len, nev, s;

   sqcr_regs dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .rx_queue_kill_bit(rx_queue_kill_bit), .rx_in_order(rx_in_order),
      .tx_flow_filter(tx_flow_filter), .tx_queue_pending(tx_queue_pending),
      .tx_msg_done(tx_msg_done), .tx_serve_valid(tx_serve_valid),
      .tx_serve_queue(tx_serve_queue));
   sqcr_tx_engine_model eng_u (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .pend_mask(pend_mask), .stall_en(stall_en),
      .tx_serve_valid(tx_serve_valid),
      .tx_queue_pending(tx_queue_pending), .tx_msg_done(tx_msg_done));

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [31:0] lfsr_next(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   // Slots map queue s to slot s, so skipping walks the queue numbers
   function automatic logic [3:0] next_q(input logic [3:0] q);
      logic [3:0] n;
      n = q + 4'h1;
      for (int i = 0; i < 16; i++)
         if (!pend_mask[n] || cnt_tab[n] == 4'h0) n = n + 4'h1;
      return n;
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] v);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic rd(input logic [11:0] a);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      // Read data stand for this one cycle only, so take them mid-cycle
      @(negedge sys_clk);
      rd_v = reg_rdata;
      @(posedge sys_clk);
   endtask
   task automatic give_verdict;
      $display("Checks %0d, errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   initial begin
      repeat (5000) @(posedge sys_clk);
      num_errors++;
      give_verdict;
   end

   // Served queues must come in slot order, each run as long as its count
   always @(posedge sys_clk) begin
      if (mon_on && tx_serve_valid && tx_msg_done) begin
         nev++;
         if (first) begin
            prev_q = tx_serve_queue;
            run_len = 1;
            first = 1'b0;
         end else if (tx_serve_queue === prev_q && run_len < cnt_tab[prev_q])
            run_len++;
         else begin
            if (!part) chk(32'(run_len), {28'h0, cnt_tab[prev_q]});
            chk({28'h0, tx_serve_queue}, {28'h0, next_q(prev_q)});
            prev_q = tx_serve_queue;
            run_len = 1;
            part = 1'b0;
         end
      end
   end

   initial begin
      sys_rst = 1'b1;
      reg_addr = 12'h000;
      reg_wdata = 32'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      pend_mask = 16'hffff;
      stall_en = 1'b0;
      mon_on = 1'b0;
      first = 1'b1;
      part = 1'b1;
      num_errors = 0;
      checks = 0;
      nev = 0;
      lfsr = 32'd91962;
      repeat (8) @(posedge sys_clk);
      sys_rst <= 1'b0;
      @(posedge sys_clk);
      chk({31'h0, &tx_flow_filter}, 32'h1);
      // All counts are zero here: slot s names queue s and nothing is taken
      rd(WRR_STATUS_ADDR);
      chk({4'h0, rd_v[31:8], rd_v[7:4]}, {28'h0, rd_v[3:0]});
      for (int k = 0; k < 8; k++) begin
         rd(FLOW_BASE_ADDR + 12'(4 * k));
         chk(rd_v, 32'hffffffff);
         lfsr = lfsr_next(lfsr);
         d = (k == 7) ? 32'h80000001 : lfsr;
         wr(FLOW_BASE_ADDR + 12'(4 * k), d);
         chk({16'h0, tx_flow_filter[32 * k +: 16]}, {16'h0, d[15:0]});
         chk({16'h0, tx_flow_filter[32 * k + 16 +: 16]}, {16'h0, d[31:16]});
         rd(FLOW_BASE_ADDR + 12'(4 * k));
         chk(rd_v, d);
      end
      rd(RX_ORDER_ADDR);
      chk(rd_v, 32'h0);
      for (int i = 0; i < 4; i++) begin
         lfsr = lfsr_next(lfsr);
         d = (i == 0) ? 32'hffff0000 : lfsr;
         wr(RX_TEARDOWN_ADDR, d);
         chk({16'h0, rx_queue_kill_bit}, {16'h0, d[15:0]});
         @(posedge sys_clk);
         chk({16'h0, rx_queue_kill_bit}, 32'h0);
         rd(RX_TEARDOWN_ADDR);
         chk(rd_v, 32'h0);
      end
      wr(RX_ORDER_ADDR, lfsr);
      chk({16'h0, rx_in_order}, {16'h0, lfsr[15:0]});
      rd(RX_ORDER_ADDR);
      chk(rd_v, {16'h0, lfsr[15:0]});
      rd(12'h7fc);
      chk(rd_v, 32'h0);
      rd(FLOW_BASE_ADDR + 12'h002);
      chk(rd_v, 32'h0);
      wr(FLOW_BASE_ADDR + 12'h01e, 32'h00000000);
      chk(tx_flow_filter[255:224], 32'h80000001);
      // Slot 5 takes the largest count, slot 9 is switched off
      for (int w = 0; w < 4; w++) begin
         rd(WRR_BASE_ADDR + 12'(4 * w));
         chk(rd_v, WRR_RESET[w]);
         for (int j = 0; j < 4; j++) begin
            s = 4 * w + j;
            lfsr = lfsr_next(lfsr);
            cnt_tab[s] = (s == 5) ? 4'hf : (s == 9) ? 4'h0 : 4'(1 + lfsr % 3);
            d[8 * j +: 8] = {cnt_tab[s], 4'(s)};
         end
         wr(WRR_BASE_ADDR + 12'(4 * w), d);
         rd(WRR_BASE_ADDR + 12'(4 * w));
         chk(rd_v, d);
      end
      for (int p = 0; p < 2; p++) begin
         first = 1'b1;
         part = 1'b1;
         mon_on <= 1'b1;
         repeat (300) @(posedge sys_clk);
         mon_on <= 1'b0;
         lfsr = lfsr_next(lfsr);
         pend_mask <= lfsr[15:0] | 16'h0101;
         stall_en <= 1'b1;
         @(posedge sys_clk);
      end
      chk(32'(nev > 40), 32'h1);
      give_verdict;
   end
endmodule // srio_queue_control_regs_tb
`default_nettype wire
